// ---- hdl/temp_trip_compare_logic.sv ----
// Threshold comparison, trip flags and alert output of the temperature sensor.
// Assumes a serial bus engine on mclk drives the register port, and a converter
// on mclk delivers each result with a one-cycle strobe.
// Notes on behaviour
// - Config bit 0 selects comparator alert (0, reset) or interrupt alert (1).
// - Alert mode bit ignores writes while either lock bit is set.
// - Below flag sets under lower minus hysteresis, clears at lower value.
// - Above flag sets over upper, clears at or under upper minus hysteresis; critical sets at critical, clears under critical minus hysteresis.
// - Temperature word top three bits show trip flags, independent of alert output.
// - Temperature reads as 12-bit two's complement, LSB 0.125 degrees.
// - Temperature word bit 0 reads zero; bit 11 weighs 128 degrees.
// - Upper threshold writable in bits 12:2; bits 15:13 and 1:0 read zero.
// - Lower threshold writable in bits 12:2; reserved bits read zero.
// - Critical threshold writable in bits 12:2; bits 15:13 and 1:0 read zero.
// - Upper threshold reserved bits ignore writes and read zero.
// - Comparisons always use the thresholds currently held.
// - Writing 1 to clear-alert clears interrupt alert; no comparator effect; reads zero.
// - Alert output enable: 0 disabled (reset), 1 enabled; frozen while locked.
// - Critical-only bit restricts alert to critical condition; else window or critical.
// - Alert polarity: 0 active low (reset), 1 active high; frozen while locked.
`include "temp_trip_defs.svh"

module temp_trip_compare_logic #(
    parameter int HYST_W = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire temp_trip_pkg::tempCode_t tempCode,
    input wire logic tempValid,
    input wire logic [HYST_W-1:0] hystCode,
    input wire logic critLock,
    input wire logic windowLock,
    input wire temp_trip_pkg::regAddr_t regAddr,
    input wire logic regWrEn,
    input wire temp_trip_pkg::regWord_t regWrData,
    input wire logic regRdEn,
    output temp_trip_pkg::regWord_t regRdData,
    output logic alertPinOut,
    output logic alertPinOe_n
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    // The hysteresis, shifted into 0.125 degree units, must fit the compare width.
    if (HYST_W < 1 || HYST_W > 11) begin : g_bad_hyst
        $error("HYST_W must lie between 1 and 11");
    end

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    temp_trip_pkg::thrCode_t upperQ, lowerQ, critQ;
    temp_trip_pkg::tempCode_t tempQ;
    logic modeQ, polQ, critOnlyQ, outEnQ;
    logic belowQ, aboveQ, critFlagQ;
    logic alertLatchQ, condPrevQ;
    temp_trip_pkg::regWord_t rdDataQ;
    logic pinOeQ;

    // Register port decode.
    wire locked = critLock | windowLock;
    wire wrCfg = regWrEn && (regAddr == `OFS_CONFIG);
    wire wrUpper = regWrEn && (regAddr == `OFS_UPPER);
    wire wrLower = regWrEn && (regAddr == `OFS_LOWER);
    wire wrCrit = regWrEn && (regAddr == `OFS_CRIT);
    wire clearReq = wrCfg && regWrData[`CFG_CLEAR_BIT];
    wire temp_trip_pkg::thrCode_t wrThr = regWrData[`THR_MSB:`THR_LSB];

    // ------------------------------------------------------------------
    // Threshold registers
    // ------------------------------------------------------------------
    // Only bits 12:2 are stored; other bits of a write are dropped.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            upperQ <= `THR_RESET;
            lowerQ <= `THR_RESET;
            critQ <= `THR_RESET;
        end else begin
            if (wrUpper) upperQ <= wrThr;
            if (wrLower) lowerQ <= wrThr;
            if (wrCrit) critQ <= wrThr;
        end
    end

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    // Mode, polarity, critical-only and output enable are frozen while locked.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            modeQ <= 1'b0;
            polQ <= 1'b0;
            critOnlyQ <= 1'b0;
            outEnQ <= 1'b0;
        end else if (wrCfg && !locked) begin
            modeQ <= regWrData[`CFG_MODE_BIT];
            polQ <= regWrData[`CFG_POL_BIT];
            critOnlyQ <= regWrData[`CFG_CRITONLY_BIT];
            outEnQ <= regWrData[`CFG_OUTEN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Comparison arithmetic
    // ------------------------------------------------------------------
    // Everything is compared in 0.125 degree units, thresholds shifted left once.
    // A concatenation is unsigned, so each threshold is made signed before it is widened.
    wire temp_trip_pkg::cmpVal_t tNew = temp_trip_pkg::cmpVal_t'(tempCode);
    wire temp_trip_pkg::cmpVal_t hyst = temp_trip_pkg::cmpVal_t'({1'b0, hystCode, 1'b0});
    wire temp_trip_pkg::cmpVal_t upperV =
        temp_trip_pkg::cmpVal_t'($signed({upperQ, 1'b0}));
    wire temp_trip_pkg::cmpVal_t lowerV =
        temp_trip_pkg::cmpVal_t'($signed({lowerQ, 1'b0}));
    wire temp_trip_pkg::cmpVal_t critV =
        temp_trip_pkg::cmpVal_t'($signed({critQ, 1'b0}));
    wire temp_trip_pkg::cmpVal_t upperLo = upperV - hyst;
    wire temp_trip_pkg::cmpVal_t lowerLo = lowerV - hyst;
    wire temp_trip_pkg::cmpVal_t critLo = critV - hyst;

    // Hysteresis band: a set flag holds until the far edge of the band.
    wire belowD = belowQ ? (tNew < lowerV) : (tNew < lowerLo);
    wire aboveD = aboveQ ? (tNew > upperLo) : (tNew > upperV);
    wire critD = critFlagQ ? (tNew >= critLo) : (tNew >= critV);

    // ------------------------------------------------------------------
    // Temperature latch and trip flags
    // ------------------------------------------------------------------
    // Flags advance only when a conversion result is latched.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tempQ <= 12'sh000;
            belowQ <= 1'b0;
            aboveQ <= 1'b0;
            critFlagQ <= 1'b0;
        end else if (tempValid) begin
            tempQ <= tempCode;
            belowQ <= belowD;
            aboveQ <= aboveD;
            critFlagQ <= critD;
        end
    end

    // ------------------------------------------------------------------
    // Alert event logic
    // ------------------------------------------------------------------
    // The alert condition honours the critical-only selection.
    wire eventCond = critOnlyQ ? critFlagQ : (critFlagQ | aboveQ | belowQ);
    wire condRise = eventCond && !condPrevQ;
    wire alertActive = modeQ ? alertLatchQ : eventCond;

    // In interrupt mode a new event sets the latch; a new event wins over a clear.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            condPrevQ <= 1'b0;
            alertLatchQ <= 1'b0;
        end else begin
            condPrevQ <= eventCond;
            if (modeQ && condRise) alertLatchQ <= 1'b1;
            else if (clearReq || !modeQ) alertLatchQ <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Alert pin
    // ------------------------------------------------------------------
    // Open drain: the pin is pulled low only when enabled and the level is low.
    wire alertStatus = outEnQ && alertActive;
    wire pinLevel = polQ ? alertStatus : !alertStatus;
    wire pinDrive = outEnQ && !pinLevel;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pinOeQ <= 1'b1;
        end else begin
            pinOeQ <= !pinDrive;
        end
    end
    assign alertPinOe_n = pinOeQ;

    // The driven level is always low, held in a constant flip-flop.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) alertPinOut <= 1'b0;
        else alertPinOut <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Read data is selected by address and registered one cycle after the request.
    wire temp_trip_pkg::regWord_t cfgWord = {10'h000, 1'b0, alertStatus, outEnQ,
                                             critOnlyQ, polQ, modeQ};
    wire temp_trip_pkg::regWord_t tempWord = {critFlagQ, aboveQ, belowQ,
                                              tempQ, 1'b0};
    wire temp_trip_pkg::regWord_t rdSel =
        (regAddr == `OFS_CONFIG) ? cfgWord :
        (regAddr == `OFS_UPPER) ? {3'h0, upperQ, 2'h0} :
        (regAddr == `OFS_LOWER) ? {3'h0, lowerQ, 2'h0} :
        (regAddr == `OFS_CRIT) ? {3'h0, critQ, 2'h0} :
        (regAddr == `OFS_TEMP) ? tempWord : 16'h0000;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) rdDataQ <= 16'h0000;
        else if (regRdEn) rdDataQ <= rdSel;
    end
    assign regRdData = rdDataQ;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_mode_lock_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        (wrCfg && locked) |=> $stable(modeQ) && $stable(polQ) && $stable(outEnQ))
        else $error("Configuration changed while locked.");

    a_mode_write_take: assert property (@(posedge mclk) disable iff (sys_rst)
        (wrCfg && !locked) |=> (modeQ == $past(regWrData[0])))
        else $error("Alert mode write not taken.");

    a_below_flag_set: assert property (@(posedge mclk) disable iff (sys_rst)
        (tempValid && !belowQ && (tNew < lowerLo)) |=> belowQ)
        else $error("Below flag failed to set.");

    a_below_flag_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        (tempValid && belowQ && (tNew >= lowerV)) |=> !belowQ)
        else $error("Below flag failed to clear.");

    a_above_flag_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        (tempValid && aboveQ && (tNew > upperLo)) |=> aboveQ)
        else $error("Above flag dropped inside hysteresis band.");

    a_crit_flag_set: assert property (@(posedge mclk) disable iff (sys_rst)
        (tempValid && (tNew >= critV)) |=> critFlagQ)
        else $error("Critical flag failed to set.");

    a_temp_word_read: assert property (@(posedge mclk) disable iff (sys_rst)
        (regRdEn && regAddr == `OFS_TEMP) |=>
        (regRdData[15:13] == $past({critFlagQ, aboveQ, belowQ})) && (regRdData[0] == 1'b0))
        else $error("Temperature word flags or bit 0 wrong.");

    a_upper_rsvd_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        (regRdEn && regAddr == `OFS_UPPER) |=>
        (regRdData[15:13] == 3'h0) && (regRdData[1:0] == 2'h0))
        else $error("Reserved threshold bits read nonzero.");

    a_clear_alert_int: assert property (@(posedge mclk) disable iff (sys_rst)
        (modeQ && clearReq && !condRise) |=> !alertLatchQ)
        else $error("Clear did not release interrupt alert.");

    a_pin_disabled: assert property (@(posedge mclk) disable iff (sys_rst)
        !outEnQ |=> alertPinOe_n)
        else $error("Alert pin driven while disabled.");

    a_crit_only_gate: assert property (@(posedge mclk) disable iff (sys_rst)
        (critOnlyQ && !modeQ && !critFlagQ) |-> !alertActive)
        else $error("Alert active without critical condition.");

    a_above_flag_set: assert property (@(posedge mclk) disable iff (sys_rst)
        (tempValid && !aboveQ && (tNew > upperV)) |=> aboveQ)
        else $error("Above flag failed to set.");

    a_above_flag_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        (tempValid && aboveQ && (tNew <= upperLo)) |=> !aboveQ)
        else $error("Above flag failed to clear.");

    a_crit_flag_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        (tempValid && critFlagQ && (tNew < critLo)) |=> !critFlagQ)
        else $error("Critical flag failed to clear.");

    a_flags_hold_idle: assert property (@(posedge mclk) disable iff (sys_rst)
        !tempValid |=> $stable({belowQ, aboveQ, critFlagQ}))
        else $error("Trip flags moved without a conversion.");

    a_temp_latch_take: assert property (@(posedge mclk) disable iff (sys_rst)
        tempValid |=> (tempQ == $past(tempCode)))
        else $error("Conversion result not latched.");

    a_upper_write_take: assert property (@(posedge mclk) disable iff (sys_rst)
        wrUpper |=> (upperQ == $past(wrThr)))
        else $error("Upper threshold write not taken.");

    a_clear_reads_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        (regRdEn && regAddr == `OFS_CONFIG) |=> !regRdData[`CFG_CLEAR_BIT])
        else $error("Clear-alert bit read nonzero.");

    a_comparator_latch_idle: assert property (@(posedge mclk) disable iff (sys_rst)
        !modeQ |=> !alertLatchQ)
        else $error("Interrupt latch set in comparator mode.");

    a_event_sets_latch: assert property (@(posedge mclk) disable iff (sys_rst)
        (modeQ && condRise) |=> alertLatchQ)
        else $error("New event did not set interrupt latch.");

    a_status_when_disabled: assert property (@(posedge mclk) disable iff (sys_rst)
        (regRdEn && regAddr == `OFS_CONFIG && !outEnQ) |=> !regRdData[`CFG_STATUS_BIT])
        else $error("Alert status read set while output disabled.");

    a_pin_low_polarity: assert property (@(posedge mclk) disable iff (sys_rst)
        (outEnQ && !polQ && alertActive) |=> !alertPinOe_n)
        else $error("Active-low alert not driven.");

    a_pin_high_polarity: assert property (@(posedge mclk) disable iff (sys_rst)
        (outEnQ && polQ && !alertActive) |=> !alertPinOe_n)
        else $error("Idle active-high alert not driven low.");

endmodule // temp_trip_compare_logic

// ---- hdl/temp_trip_defs.svh ----
// Register offsets, field positions, reset values and widths of the trip logic.
// Assumes inclusion by bare name from the design module and the testbench.
`ifndef TEMP_TRIP_DEFS_SVH
`define TEMP_TRIP_DEFS_SVH

// ------------------------------------------------------------------
// Register offsets on the internal register port
// ------------------------------------------------------------------
`define OFS_CONFIG 8'h01
`define OFS_UPPER 8'h02
`define OFS_LOWER 8'h03
`define OFS_CRIT 8'h04
`define OFS_TEMP 8'h05

// ------------------------------------------------------------------
// Configuration register bit positions
// ------------------------------------------------------------------
`define CFG_MODE_BIT 0
`define CFG_POL_BIT 1
`define CFG_CRITONLY_BIT 2
`define CFG_OUTEN_BIT 3
`define CFG_STATUS_BIT 4
`define CFG_CLEAR_BIT 5

// ------------------------------------------------------------------
// Threshold and temperature word layout
// ------------------------------------------------------------------
`define THR_MSB 12
`define THR_LSB 2
`define TEMP_MSB 12
`define TEMP_LSB 1
`define FLAG_BELOW_BIT 13
`define FLAG_ABOVE_BIT 14
`define FLAG_CRIT_BIT 15
`define THR_RESET 11'h000
`define CFG_RESET 16'h0000

`endif

// ---- hdl/temp_trip_pkg.sv ----
// Types shared by the trip comparison logic and its surroundings.
// Assumes the defs header is on the include path.
package temp_trip_pkg;
    typedef logic [7:0] regAddr_t;
    typedef logic [15:0] regWord_t;
    typedef logic signed [10:0] thrCode_t;
    typedef logic signed [11:0] tempCode_t;
    typedef logic signed [14:0] cmpVal_t;
endpackage

// ---- testbench/temp_trip_compare_logic_tb_top.sv ----
// Self-checking bench of the trip logic, with the host model on its register port.
// Assumes the defs header is on the include path and the alert pin has a pull-up.
`include "temp_trip_defs.svh"
`define CHECK_EQ(got, exp, msg) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp); \
    end \
end
module temp_trip_compare_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk;
    logic sys_rst;
    temp_trip_pkg::tempCode_t tempCode;
    logic tempValid;
    logic [3:0] hystCode;
    logic critLock;
    logic windowLock;
    temp_trip_pkg::regAddr_t regAddr;
    logic regWrEn;
    temp_trip_pkg::regWord_t regWrData;
    logic regRdEn;
    temp_trip_pkg::regWord_t regRdData;
    logic alertPinOut;
    logic alertPinOe_n;
    logic pinLevel;
    int n_errors;
    int compares;
    // -----------------------------------------------------------
    // Instances and pin level
    // -----------------------------------------------------------
    temp_trip_compare_logic #(.HYST_W(4)) uut (.mclk(mclk), .sys_rst(sys_rst),
        .tempCode(tempCode), .tempValid(tempValid), .hystCode(hystCode),
        .critLock(critLock), .windowLock(windowLock), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .alertPinOut(alertPinOut), .alertPinOe_n(alertPinOe_n));
    trip_host_model host (.mclk(mclk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
    // The pull-up holds the pin high whenever the device releases it.
    assign pinLevel = alertPinOe_n ? 1'b1 : alertPinOut;
    // -----------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("Errors %0d, comparisons %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Reads one register and compares it with the expected word.
    task automatic chkReg(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.rd(a, d);
        `CHECK_EQ(d, e, "register read")
    endtask
    // Lets the alert path settle, then checks the pin level.
    task automatic chkPin(input logic e);
        repeat (4) @(posedge mclk);
        #1;
        `CHECK_EQ(pinLevel, e, "alert pin")
    endtask
    // Hands one conversion result to the block with a one-cycle strobe.
    task automatic conv(input logic [11:0] c);
        @(posedge mclk);
        tempCode <= c;
        tempValid <= 1'b1;
        @(posedge mclk);
        tempValid <= 1'b0;
        tempCode <= ~c;
    endtask
    // -----------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------
    // Thresholds keep bits 12:2 only, whatever else is written.
    task automatic tThresholds;
        logic [7:0] ofs[3] = '{`OFS_UPPER, `OFS_LOWER, `OFS_CRIT};
        foreach (ofs[i]) begin
            host.wr(ofs[i], 16'hFFFF);
            chkReg(ofs[i], 16'h1FFC);
            host.wr(ofs[i], 16'hE003);
            chkReg(ofs[i], 16'h0000);
        end
    endtask
    // Walks the temperature across every set and clear point of the three flags.
    task automatic tFlags;
        logic [11:0] code[11] = '{12'h0C9, 12'h0C4, 12'h0C0, 12'h024, 12'h01F,
            12'h027, 12'h028, 12'h190, 12'h18A, 12'h187, 12'hF32};
        logic [15:0] word[11] = '{16'h4192, 16'h4188, 16'h0180, 16'h0048, 16'h203E,
            16'h204E, 16'h0050, 16'hC320, 16'hC314, 16'h430E, 16'h3E64};
        host.wr(`OFS_CONFIG, 16'h0000);
        host.wr(`OFS_UPPER, 16'h0190);
        host.wr(`OFS_LOWER, 16'h0050);
        host.wr(`OFS_CRIT, 16'h0320);
        foreach (code[i]) begin
            conv(code[i]);
            chkReg(`OFS_TEMP, word[i]);
        end
        host.wr(`OFS_LOWER, 16'h1FB0);
        chkReg(`OFS_LOWER, 16'h1FB0);
        conv(12'hFE8);
        chkReg(`OFS_TEMP, 16'h1FD0);
        conv(12'hFC8);
        chkReg(`OFS_TEMP, 16'h3F90);
        host.wr(`OFS_UPPER, 16'h0180);
        conv(12'h0C4);
        chkReg(`OFS_TEMP, 16'h4188);
    endtask
    // Comparator output, clear without effect, critical-only and polarity.
    task automatic tComparator;
        host.wr(`OFS_CONFIG, 16'h0008);
        chkPin(1'b0);
        chkReg(`OFS_CONFIG, 16'h0018);
        host.wr(`OFS_CONFIG, 16'h0028);
        chkPin(1'b0);
        host.wr(`OFS_CONFIG, 16'h000C);
        chkPin(1'b1);
        conv(12'h190);
        chkPin(1'b0);
        host.wr(`OFS_CONFIG, 16'h000E);
        chkPin(1'b1);
        conv(12'h0C4);
        chkPin(1'b0);
    endtask
    // Interrupt output latches the event until the host clears it.
    task automatic tInterrupt;
        host.wr(`OFS_CONFIG, 16'h0000);
        conv(12'h0A0);
        host.wr(`OFS_CONFIG, 16'h0009);
        chkPin(1'b1);
        conv(12'h0C4);
        chkPin(1'b0);
        conv(12'h0A0);
        chkPin(1'b0);
        chkReg(`OFS_TEMP, 16'h0140);
        chkReg(`OFS_CONFIG, 16'h0019);
        host.wr(`OFS_CONFIG, 16'h0029);
        chkPin(1'b1);
        chkReg(`OFS_CONFIG, 16'h0009);
    endtask
    // Either lock freezes the mode, polarity, critical-only and enable bits.
    task automatic tLocks;
        @(posedge mclk) critLock <= 1'b1;
        host.wr(`OFS_CONFIG, 16'h0006);
        chkReg(`OFS_CONFIG, 16'h0009);
        @(posedge mclk) critLock <= 1'b0;
        windowLock <= 1'b1;
        host.wr(`OFS_CONFIG, 16'h0000);
        chkReg(`OFS_CONFIG, 16'h0009);
        @(posedge mclk) windowLock <= 1'b0;
        host.wr(`OFS_CONFIG, 16'h0000);
        chkReg(`OFS_CONFIG, 16'h0000);
    endtask
    // A reset in mid-run returns the configuration, the lower threshold, the temperature word with its flags, and the pin to reset state.
    task automatic tReset;
        host.wr(`OFS_CONFIG, 16'h000F);
        conv(12'h190);
        @(posedge mclk) sys_rst <= 1'b1;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        chkReg(`OFS_CONFIG, 16'h0000);
        chkReg(`OFS_LOWER, 16'h0000);
        chkReg(`OFS_TEMP, 16'h0000);
        chkPin(1'b1);
    endtask
    // -----------------------------------------------------------
    // Clock, watchdog and main sequence
    // -----------------------------------------------------------
    // Free-running 100 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Cuts a hang short and counts it as a mismatch.
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        stop_test();
    end
    // Resets the block, checks reset values, then runs every scenario.
    initial begin
        n_errors = 0;
        compares = 0;
        sys_rst = 1'b1;
        tempCode = 12'h000;
        tempValid = 1'b0;
        hystCode = 4'h4;
        critLock = 1'b0;
        windowLock = 1'b0;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        chkReg(`OFS_CONFIG, 16'h0000);
        chkReg(`OFS_UPPER, 16'h0000);
        chkReg(`OFS_LOWER, 16'h0000);
        chkReg(`OFS_CRIT, 16'h0000);
        chkReg(8'h7F, 16'h0000);
        chkPin(1'b1);
        tThresholds();
        tFlags();
        tComparator();
        tInterrupt();
        tLocks();
        tReset();
        stop_test();
    end
endmodule // temp_trip_compare_logic_tb_top

// ---- testbench/trip_host_model.sv ----
// Host model that drives the register port of the trip logic.
// Assumes the trip logic samples the port on the rising edge of mclk.
module trip_host_model (
    input wire logic mclk,
    output temp_trip_pkg::regAddr_t regAddr,
    output logic regWrEn,
    output temp_trip_pkg::regWord_t regWrData,
    output logic regRdEn,
    input wire temp_trip_pkg::regWord_t regRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero.
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 16'h0000;
        regRdEn = 1'b0;
    end

    // One word write; released data shows the inverse so stale values never match.
    task automatic wr(input temp_trip_pkg::regAddr_t a, input temp_trip_pkg::regWord_t d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
        regWrData <= ~d;
    endtask

    // One word read; data is taken a step after the edge that samples the strobe.
    task automatic rd(input temp_trip_pkg::regAddr_t a, output temp_trip_pkg::regWord_t d);
        @(posedge mclk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
    endtask
endmodule // trip_host_model
